//--- core/daopc_top.sv
// Dual converter output and power control: pins, slow-clock power down,
// per-channel output stages and a classic Wishbone register slave.
// Assumes the analog core delivers offset-binary codes on the sample clock.
`timescale 1ns/1ps
module daopc_top #(
  parameter int W = daopc_pkg::SAMPLE_W
) (
  // System clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [daopc_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  // Control pins
  input  wire logic                         power_down_select_i,
  input  wire logic                         output_enable_chan_a_i,
  input  wire logic                         output_enable_chan_b_i,
  // Sample clock and core codes
  input  wire logic                         sample_clock_pos_i,
  input  wire logic [W-1:0]                 raw_a_i,
  input  wire logic [W-1:0]                 raw_b_i,
  // Converter power to the analog core
  output logic                              adc_run_a_o,
  output logic                              adc_run_b_o,
  // Channel A bus
  output logic [W-1:0]                      sample_a_o,
  output logic                              out_of_range_flag_a_o,
  output logic                              data_ready_clock_a_o,
  output logic                              chan_a_oe_o,
  // Channel B bus
  output logic [W-1:0]                      sample_b_o,
  output logic                              out_of_range_flag_b_o,
  output logic                              data_ready_clock_b_o,
  output logic                              chan_b_oe_o
);
  localparam int PW = daopc_pkg::PERIOD_W;
  localparam logic [PW-1:0] SLOW_LIM = PW'(daopc_pkg::SLOW_CYCLES - 1);
  localparam logic [PW-1:0] CNT_TOP  = {PW{1'b1}};

  typedef struct packed {
    logic [daopc_pkg::CTRL_W-1:0] ctrl;
    logic [PW-1:0]                cnt;
    logic [PW-1:0]                period;
    logic                         tick_seen;
    logic                         slow;
    logic                         run_a;
    logic                         run_b;
    logic                         oe_a;
    logic                         oe_b;
    logic                         ack;
    logic [31:0]                  rdata;
  } daopc_sys_t;

  typedef struct packed {
    logic tick;
  } daopc_link_t;

  daopc_sys_t  st;
  daopc_sys_t  next_st;
  daopc_link_t lst;
  daopc_link_t next_lst;

  logic [2:0]   pin_s;
  logic         tick_s;
  logic         tick_edge;
  logic         slow_eff;
  logic         link_rst;
  logic [1:0]   run_l;
  logic         wb_req;
  logic [W-1:0] raw_arr    [2];
  logic [W-1:0] sample_arr [2];
  logic [1:0]   range_arr;
  logic [1:0]   ready_arr;

  // Pins are asynchronous to both clocks
  daopc_sync #(.W(3)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({output_enable_chan_b_i, output_enable_chan_a_i, power_down_select_i}),
    .q_o   (pin_s)
  );

  // Link tick toggles once per sample clock period
  daopc_sync #(.W(1)) u_tick_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (lst.tick),
    .q_o   (tick_s)
  );

  // Reset carried into the sample clock domain
  daopc_sync #(.W(1)) u_rst_sync (
    .clk_i (sample_clock_pos_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  // Channel run levels carried into the sample clock domain
  daopc_sync #(.W(2)) u_run_sync (
    .clk_i (sample_clock_pos_i),
    .rst_i (link_rst),
    .d_i   ({st.run_b, st.run_a}),
    .q_o   (run_l)
  );

  assign tick_edge = tick_s != st.tick_seen;
  assign slow_eff  = st.slow && st.ctrl[daopc_pkg::CTRL_DETECT];
  assign wb_req    = wb_cyc_i && wb_stb_i;

  always_comb begin
    next_st           = st;
    next_st.tick_seen = tick_s;
    // Gap measured in system cycles between sample clock edges
    if (tick_edge) begin
      next_st.period = st.cnt;
      next_st.cnt    = '0;
      // Only a fast gap wakes the core, so a slow clock stays down
      if (st.cnt < SLOW_LIM) begin
        next_st.slow = 1'b0;
      end
    end else begin
      if (st.cnt != CNT_TOP) begin
        next_st.cnt = st.cnt + 1'b1;
      end
      if (st.cnt >= SLOW_LIM) begin
        next_st.slow = 1'b1;
      end
    end
    // Power table: select low keeps both running, high follows enables
    next_st.run_a = !slow_eff && !st.ctrl[daopc_pkg::CTRL_FORCE_A]
                    && (!pin_s[daopc_pkg::PIN_PDN] || pin_s[daopc_pkg::PIN_OEA]);
    next_st.run_b = !slow_eff && !st.ctrl[daopc_pkg::CTRL_FORCE_B]
                    && (!pin_s[daopc_pkg::PIN_PDN] || pin_s[daopc_pkg::PIN_OEB]);
    // Bus drive depends on the enable alone
    next_st.oe_a = pin_s[daopc_pkg::PIN_OEA];
    next_st.oe_b = pin_s[daopc_pkg::PIN_OEB];
    // Wishbone: answer one cycle after the request, then drop
    next_st.ack = wb_req && !st.ack;
    if (wb_req && !st.ack) begin
      case (wb_adr_i)
        daopc_pkg::REG_CTRL: begin
          next_st.rdata = {29'h0000000, st.ctrl};
        end
        daopc_pkg::REG_STATUS: begin
          next_st.rdata = {26'h0000000, st.run_b, st.run_a, st.slow, pin_s};
        end
        daopc_pkg::REG_PERIOD: begin
          next_st.rdata = {24'h000000, st.period};
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
    // Write lands on the edge where the master sees the answer
    if (wb_req && st.ack && wb_we_i && wb_sel_i[0]
        && wb_adr_i == daopc_pkg::REG_CTRL) begin
      next_st.ctrl = wb_dat_i[daopc_pkg::CTRL_W-1:0];
    end
    if (rst_i) begin
      next_st      = '0;
      next_st.ctrl = daopc_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  always_comb begin
    next_lst.tick = ~lst.tick;
    if (link_rst) begin
      next_lst.tick = 1'b0;
    end
  end

  always_ff @(posedge sample_clock_pos_i) begin
    lst <= next_lst;
  end

  assign raw_arr[0] = raw_a_i;
  assign raw_arr[1] = raw_b_i;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    daopc_chan #(.W(W)) u_chan (
      .clk_i    (sample_clock_pos_i),
      .rst_i    (link_rst),
      .run_i    (run_l[c]),
      .raw_i    (raw_arr[c]),
      .sample_o (sample_arr[c]),
      .range_o  (range_arr[c]),
      .ready_o  (ready_arr[c])
    );
  end

  assign wb_dat_o              = st.rdata;
  assign wb_ack_o              = st.ack;
  assign adc_run_a_o           = st.run_a;
  assign adc_run_b_o           = st.run_b;
  assign chan_a_oe_o           = st.oe_a;
  assign chan_b_oe_o           = st.oe_b;
  assign sample_a_o            = sample_arr[0];
  assign sample_b_o            = sample_arr[1];
  assign out_of_range_flag_a_o = range_arr[0];
  assign out_of_range_flag_b_o = range_arr[1];
  assign data_ready_clock_a_o  = ready_arr[0];
  assign data_ready_clock_b_o  = ready_arr[1];

  // Cycles since the last seen sample clock edge, for checking only
  logic [PW-1:0] gap;
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_edge) begin
      gap <= '0;
    end else if (gap != CNT_TOP) begin
      gap <= gap + 1'b1;
    end
  end

  property p_slow_clock_down;
    @(posedge clk_i) disable iff (rst_i)
    (st.ctrl[daopc_pkg::CTRL_DETECT] && $past(st.ctrl[daopc_pkg::CTRL_DETECT])
     && gap > SLOW_LIM + 8'h02) |-> (!adc_run_a_o && !adc_run_b_o);
  endproperty
  a_slow_clock_down: assert property (p_slow_clock_down)
    else $error("core still running on a slow sample clock");

  property p_select_low_runs;
    @(posedge clk_i) disable iff (rst_i)
    (!pin_s[daopc_pkg::PIN_PDN] && !slow_eff && st.ctrl[2:1] == 2'b00)
    |=> (adc_run_a_o && adc_run_b_o);
  endproperty
  a_select_low_runs: assert property (p_select_low_runs)
    else $error("converter off with power down select low");

  property p_select_high_off;
    @(posedge clk_i) disable iff (rst_i)
    (pin_s[daopc_pkg::PIN_PDN] && !pin_s[daopc_pkg::PIN_OEA]) |=> !adc_run_a_o;
  endproperty
  a_select_high_off: assert property (p_select_high_off)
    else $error("channel A running with select high and enable low");

  property p_select_high_on;
    @(posedge clk_i) disable iff (rst_i)
    (pin_s[daopc_pkg::PIN_PDN] && pin_s[daopc_pkg::PIN_OEB] && !slow_eff
     && !st.ctrl[daopc_pkg::CTRL_FORCE_B]) |=> adc_run_b_o;
  endproperty
  a_select_high_on: assert property (p_select_high_on)
    else $error("channel B off with select and enable high");

  property p_enable_floats;
    @(posedge clk_i) disable iff (rst_i)
    (!output_enable_chan_a_i)[*3] |=> !chan_a_oe_o;
  endproperty
  a_enable_floats: assert property (p_enable_floats)
    else $error("channel A bus driven with enable low");

  property p_enable_drives;
    @(posedge clk_i) disable iff (rst_i)
    (output_enable_chan_b_i)[*3] |=> chan_b_oe_o;
  endproperty
  a_enable_drives: assert property (p_enable_drives)
    else $error("channel B bus floated with enable high");

  property p_enable_floats_b;
    @(posedge clk_i) disable iff (rst_i)
    (!output_enable_chan_b_i)[*3] |=> !chan_b_oe_o;
  endproperty
  a_enable_floats_b: assert property (p_enable_floats_b)
    else $error("channel B bus driven with enable low");

  property p_enable_drives_a;
    @(posedge clk_i) disable iff (rst_i)
    (output_enable_chan_a_i)[*3] |=> chan_a_oe_o;
  endproperty
  a_enable_drives_a: assert property (p_enable_drives_a)
    else $error("channel A bus floated with enable high");

  property p_select_high_off_b;
    @(posedge clk_i) disable iff (rst_i)
    (pin_s[daopc_pkg::PIN_PDN] && !pin_s[daopc_pkg::PIN_OEB]) |=> !adc_run_b_o;
  endproperty
  a_select_high_off_b: assert property (p_select_high_off_b)
    else $error("channel B running with select high and enable low");

  property p_select_high_on_a;
    @(posedge clk_i) disable iff (rst_i)
    (pin_s[daopc_pkg::PIN_PDN] && pin_s[daopc_pkg::PIN_OEA] && !slow_eff
     && !st.ctrl[daopc_pkg::CTRL_FORCE_A]) |=> adc_run_a_o;
  endproperty
  a_select_high_on_a: assert property (p_select_high_on_a)
    else $error("channel A off with select and enable high");

  // Bus drive tracks the enables alone, whatever the run state
  property p_oe_follows_pin;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (chan_a_oe_o == $past(pin_s[daopc_pkg::PIN_OEA]))
             && (chan_b_oe_o == $past(pin_s[daopc_pkg::PIN_OEB]));
  endproperty
  a_oe_follows_pin: assert property (p_oe_follows_pin)
    else $error("bus drive does not follow its enable");

  property p_force_off;
    @(posedge clk_i) disable iff (rst_i)
    st.ctrl[daopc_pkg::CTRL_FORCE_A] |=> !adc_run_a_o;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("channel A running while forced off");

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("bus acknowledge held longer than one cycle");

  c_slow_entry: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.slow));
  c_single_chan: cover property (@(posedge clk_i) disable iff (rst_i)
    adc_run_a_o && !adc_run_b_o && chan_a_oe_o);
  c_ctrl_write: cover property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && wb_we_i && wb_adr_i == daopc_pkg::REG_CTRL);
  c_float_running: cover property (@(posedge clk_i) disable iff (rst_i)
    adc_run_a_o && !chan_a_oe_o);
  c_all_off: cover property (@(posedge clk_i) disable iff (rst_i)
    !adc_run_a_o && !adc_run_b_o && !chan_a_oe_o && !chan_b_oe_o);
endmodule

//--- inc/daopc_pkg.sv
// Constants for the dual converter output and power control block.
// Assumes a 20 MHz system clock and a sample clock of unrelated phase.
package daopc_pkg;
  localparam int SAMPLE_W = 14;
  localparam int ADR_W    = 4;
  localparam int PERIOD_W = 8;

  // Register byte offsets
  localparam logic [ADR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADR_W-1:0] REG_PERIOD = 4'h8;

  // Control field positions and reset value
  localparam int CTRL_DETECT  = 0;
  localparam int CTRL_FORCE_A = 1;
  localparam int CTRL_FORCE_B = 2;
  localparam int CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h1;

  // Status field positions
  localparam int ST_PDN   = 0;
  localparam int ST_OEA   = 1;
  localparam int ST_OEB   = 2;
  localparam int ST_SLOW  = 3;
  localparam int ST_RUN_A = 4;
  localparam int ST_RUN_B = 5;

  // Order of the synchronised pins
  localparam int PIN_PDN = 0;
  localparam int PIN_OEA = 1;
  localparam int PIN_OEB = 2;

  // Sample clock slower than this period powers the core down
  localparam int SYS_PERIOD_NS  = 50;
  localparam int SLOW_PERIOD_NS = 1000;
  localparam int SLOW_CYCLES    = (SLOW_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // Two's-complement full-scale limits
  localparam logic [SAMPLE_W-1:0] CODE_MAX  = 14'h1FFF;
  localparam logic [SAMPLE_W-1:0] CODE_MIN  = 14'h2000;
  localparam logic [SAMPLE_W-1:0] CODE_IDLE = 14'h0000;
endpackage

//--- core/daopc_sync.sv
// Two-flop level synchroniser.
// Assumes a synchronous active-high reset in the destination domain.
`timescale 1ns/1ps
module daopc_sync #(
  parameter int W = 1
) (
  // Destination domain
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } daopc_sync_t;

  daopc_sync_t st;
  daopc_sync_t next_st;

  always_comb begin
    next_st.meta   = d_i;
    next_st.stable = st.meta;
    if (rst_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign q_o = st.stable;
endmodule

//--- core/daopc_chan.sv
// One channel's parallel output stage on the sample clock.
// Assumes raw core codes in offset binary, valid at each sample edge.
`timescale 1ns/1ps
module daopc_chan #(
  parameter int W = daopc_pkg::SAMPLE_W
) (
  // Sample clock domain
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Core side
  input  wire logic         run_i,
  input  wire logic [W-1:0] raw_i,
  // Pins
  output logic      [W-1:0] sample_o,
  output logic              range_o,
  output logic              ready_o
);
  typedef struct packed {
    logic [W-1:0] sample;
    logic         range;
    logic         ready;
  } daopc_chan_t;

  daopc_chan_t      st;
  daopc_chan_t      next_st;
  logic     [W-1:0] conv;
  logic             hit;

  assign conv = {~raw_i[W-1], raw_i[W-2:0]};
  assign hit  = (conv == daopc_pkg::CODE_MAX) || (conv == daopc_pkg::CODE_MIN);

  always_comb begin
    next_st = st;
    if (rst_i || !run_i) begin
      // Quiet bus while the channel is down
      next_st.sample = daopc_pkg::CODE_IDLE;
      next_st.range  = 1'b0;
      next_st.ready  = 1'b0;
    end else begin
      next_st.sample = conv;
      next_st.range  = hit;
      next_st.ready  = ~st.ready;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign sample_o = st.sample;
  assign range_o  = st.range;
  assign ready_o  = st.ready;

  property p_word_format;
    @(posedge clk_i) disable iff (rst_i)
    run_i |=> sample_o == $past(conv);
  endproperty
  a_word_format: assert property (p_word_format)
    else $error("sample word not the converted code");

  property p_range_flag;
    @(posedge clk_i) disable iff (rst_i)
    run_i |=> range_o == $past(hit);
  endproperty
  a_range_flag: assert property (p_range_flag)
    else $error("range flag disagrees with full-scale test");

  property p_ready_clock;
    @(posedge clk_i) disable iff (rst_i)
    run_i ##1 run_i |=> ready_o != $past(ready_o);
  endproperty
  a_ready_clock: assert property (p_ready_clock)
    else $error("data ready clock failed to toggle");
endmodule

//--- dv/daopc_rx.sv
// Receiver model for one channel's parallel sample bus.
// Assumes each data ready edge carries a settled word and flag.
`timescale 1ns/1ps
module daopc_rx (
  // Channel bus
  input  wire logic        ready_i,
  input  wire logic        oe_i,
  input  wire logic        run_i,
  input  wire logic [13:0] word_i,
  input  wire logic        flag_i,
  // Captured sample
  output logic      [13:0] word_o,
  output logic             flag_o,
  output int               cnt_o
);
  initial begin
    word_o = 14'h0000;
    flag_o = 1'b0;
    cnt_o  = 0;
  end

  // Both edges carry a word; a floated or down channel is ignored
  // Word and ready leave the same flop; look once both have settled
  always @(ready_i) begin
    #1;
    if (oe_i && run_i) begin
      word_o <= word_i;
      flag_o <= flag_i;
      cnt_o  <= cnt_o + 1;
    end
  end
endmodule

//--- dv/daopc_top_test.sv
// Self-checking bench for the dual converter output and power control block.
// Assumes the design's own assertions; drives pins, codes and Wishbone.
`timescale 1ns/1ps
module daopc_top_test;
  logic        clk, rst, cyc, stb, we, power_down_select, output_enable_chan_a, output_enable_chan_b, sclk, sclk_en;
  logic        ack, run_a, run_b, flg_a, flg_b, rdy_a, rdy_b, oe_a, oe_b;
  logic        cf_a, cf_b;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, dat_o;
  logic [13:0] raw_a, raw_b, smp_a, smp_b, cap_a, cap_b, ea, eb;
  int          n_a, n_b, error_cnt, total_checks;

  daopc_top u_daopc_top (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .power_down_select_i(power_down_select), .output_enable_chan_a_i(output_enable_chan_a),
    .output_enable_chan_b_i(output_enable_chan_b), .sample_clock_pos_i(sclk), .raw_a_i(raw_a),
    .raw_b_i(raw_b), .adc_run_a_o(run_a), .adc_run_b_o(run_b), .sample_a_o(smp_a),
    .out_of_range_flag_a_o(flg_a), .data_ready_clock_a_o(rdy_a), .chan_a_oe_o(oe_a),
    .sample_b_o(smp_b), .out_of_range_flag_b_o(flg_b), .data_ready_clock_b_o(rdy_b),
    .chan_b_oe_o(oe_b));

  daopc_rx rx_a (.ready_i(rdy_a), .oe_i(oe_a), .run_i(run_a), .word_i(smp_a),
    .flag_i(flg_a), .word_o(cap_a), .flag_o(cf_a), .cnt_o(n_a));
  daopc_rx rx_b (.ready_i(rdy_b), .oe_i(oe_b), .run_i(run_b), .word_i(smp_b),
    .flag_i(flg_b), .word_o(cap_b), .flag_o(cf_b), .cnt_o(n_b));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Sample clock stands still while disabled, as a slowed source would
  initial begin
    sclk = 1'b0;
    #7;
    forever #24 if (sclk_en) sclk = ~sclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: bus timeout", $time);
      finish_test();
    end else begin
      @(posedge clk);
    end
  endtask

  task automatic set_pins(input logic p, input logic a, input logic b);
    @(posedge clk);
    power_down_select <= p;
    output_enable_chan_a <= a;
    output_enable_chan_b <= b;
    wait_clk(6);
  endtask

  task automatic t_regs();
    wb(1'b0, daopc_pkg::REG_CTRL, 32'h0);
    chk(rdat, 32'(daopc_pkg::CTRL_RESET), "ctrl reset");
    wb(1'b1, 4'hC, 32'hFFFFFFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk(rdat, 32'h0, "unmapped read");
    wb(1'b0, daopc_pkg::REG_CTRL, 32'h0);
    chk(rdat, 32'(daopc_pkg::CTRL_RESET), "ctrl after stray write");
    wb(1'b1, daopc_pkg::REG_CTRL, 32'h6);
    wait_clk(2);
    chk({run_b, run_a}, 2'b00, "forced off");
    wb(1'b0, daopc_pkg::REG_CTRL, 32'h0);
    chk(rdat, 32'h6, "ctrl readback");
    wb(1'b1, daopc_pkg::REG_CTRL, 32'(daopc_pkg::CTRL_RESET));
    $display("test regs done");
  endtask

  task automatic t_pins();
    int c0, c1;
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      set_pins(v[2], v[1], v[0]);
      chk(oe_a, v[1], "oe a");
      chk(oe_b, v[0], "oe b");
      chk(run_a, !v[2] || v[1], "run a");
      chk(run_b, !v[2] || v[0], "run b");
      c0 = n_a;
      c1 = n_b;
      wb(1'b0, daopc_pkg::REG_STATUS, 32'h0);
      chk(rdat[2:0], {v[0], v[1], v[2]}, "pin status");
      chk(n_a != c0, v[1], "ready a active");
      chk(n_b != c1, v[0], "ready b active");
    end
    $display("test pins done");
  endtask

  task automatic t_data();
    logic [13:0] codes [5] = '{14'h3FFF, 14'h0000, 14'h2000, 14'h1FFF, 14'h0ABC};
    set_pins(1'b0, 1'b1, 1'b1);
    foreach (codes[i]) begin
      @(posedge clk);
      raw_a <= codes[i];
      raw_b <= ~codes[i];
      wait_clk(6);
      ea = codes[i] ^ 14'h2000;
      eb = ~codes[i] ^ 14'h2000;
      chk(smp_a, ea, "word a");
      chk(smp_b, eb, "word b");
      chk(cap_a, ea, "captured a");
      chk(flg_a, ea == 14'h1FFF || ea == 14'h2000, "range a");
      chk(cf_b, eb == 14'h1FFF || eb == 14'h2000, "range b");
    end
    $display("test data done");
  endtask

  task automatic t_slow();
    @(posedge clk);
    sclk_en <= 1'b0;
    wait_clk(15);
    sclk_en <= 1'b1;
    wait_clk(4);
    chk(run_a, 1'b1, "short gap keeps run");
    sclk_en <= 1'b0;
    wait_clk(30);
    chk(run_a, 1'b0, "slow clock a down");
    chk(run_b, 1'b0, "slow clock b down");
    chk(oe_a, 1'b1, "bus still driven");
    wb(1'b0, daopc_pkg::REG_STATUS, 32'h0);
    chk(rdat[daopc_pkg::ST_SLOW], 1'b1, "slow status");
    sclk_en <= 1'b1;
    wait_clk(8);
    chk(run_a, 1'b1, "clock back");
    wb(1'b0, daopc_pkg::REG_PERIOD, 32'h0);
    chk(rdat[31:1], 31'h0, "period near one cycle");
    wb(1'b1, daopc_pkg::REG_CTRL, 32'h0);
    sclk_en <= 1'b0;
    wait_clk(30);
    chk(run_a, 1'b1, "detect off keeps run");
    sclk_en <= 1'b1;
    wb(1'b1, daopc_pkg::REG_CTRL, 32'h1);
    $display("test slow done");
  endtask

  initial begin
    {cyc, stb, we, power_down_select} = 4'h0;
    {output_enable_chan_a, output_enable_chan_b, sclk_en} = 3'h7;
    adr = 4'h0;
    wdat = 32'h0;
    raw_a = 14'h0000;
    raw_b = 14'h0000;
    error_cnt = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pins();
    t_data();
    t_slow();
    finish_test();
  end
endmodule
